/* File: serial_flash_erase_commands_bench.sv */
// self-checking bench for the block, sector and chip erase sequencer
// assumes sfe_pkg, sfe_erase_seq and sfe_host_model are compiled first
`timescale 1ns/1ps
module serial_flash_erase_commands_bench;
  import sfe_pkg::*;
  // erase counts shortened, but long enough for a whole frame to fit inside a chip erase
  localparam int BLK = 600;
  localparam int SEC = 700;
  localparam int CHP = 800;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wpN = 1'b1;
  logic pageMode256 = 1'b0;
  logic [SECTOR_COUNT-1:0] sectorProtect = '0;
  logic byteFailDet = 1'b0;
  logic sck, csN, mosi, eraseStart, wpActive, wpSeen, m;
  logic [7:0] eraseFillData;
  logic [11:0] pg;
  logic [47:0] f;
  sfe_status_type status;
  sfe_req_type eraseReq;
  int errCount = 0;
  int checked = 0;
  int starts = 0;
  int busyLen = 0;
  int cycles = 0;
  int n, s0;
  integer seed = 66;

  sfe_host_model host (.sck(sck), .csN(csN), .mosi(mosi));
  sfe_erase_seq #(.BLOCK_CYCLES(BLK), .SECTOR_CYCLES(SEC), .CHIP_CYCLES(CHP)) DUT (
    .clk(clk), .sys_rst(sys_rst), .sck(sck), .csN(csN), .mosi(mosi), .wpN(wpN),
    .pageMode256(pageMode256), .sectorProtect(sectorProtect), .byteFailDet(byteFailDet),
    .status(status), .eraseReq(eraseReq), .eraseStart(eraseStart), .wpActive(wpActive),
    .eraseFillData(eraseFillData));

  // ==========================================================
  // clock, launch counting and hang limit; outputs read on the falling edge where they are settled
  always #4 clk = ~clk;

  always @(negedge clk) begin
    cycles++;
    if (eraseStart === 1'b1) begin
      starts++;
      busyLen = 0;
      wpSeen = 1'b0;
    end
    if (status.busy === 1'b1) begin
      busyLen++;
      wpSeen = wpSeen | wpActive;
    end
    if (cycles > 60000) begin
      errCount++;
      give_verdict();
    end
  end

  // ==========================================================
  // compares, expectations and bus tasks
  task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    cmpVal({31'h0, got}, {31'h0, exp});
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // dummy bits stay random on purpose so the decoder must ignore them
  function automatic logic [23:0] mkAddr(input logic [11:0] p, input logic mode);
    logic [23:0] a;
    a = 24'($random(seed));
    if (mode) a[19:8] = p;
    else a[20:9] = p;
    return a;
  endfunction

  function automatic logic [31:0] expSector(input logic [11:0] p);
    if (p[11:8] == 4'h0) return {31'h0, p[3]};
    return {28'h0, p[11:8]} + 32'h1;
  endfunction

  task automatic go(input logic [47:0] fr, input int nb, input logic expStart);
    s0 = starts;
    host.sendFrame(fr, nb);
    for (int k = 0; k < 12 && starts == s0; k++) tick(1);
    tick(2);
    cmpBit(starts != s0, expStart);
    cmpBit(status.busy, expStart);
  endtask

  task automatic inject();
    @(posedge clk) byteFailDet <= 1'b1;
    @(posedge clk) byteFailDet <= 1'b0;
    tick(2);
    cmpBit(status.eraseProgramErrorFlag, 1'b1);
  endtask

  // busy may trail the count by the launch and release registers
  task automatic waitDone(input int cnt);
    for (int k = 0; k < CHP + 20 && status.busy === 1'b1; k++) tick(1);
    cmpBit(busyLen >= cnt && busyLen <= cnt + 2, 1'b1);
    tick(1);
    cmpVal(eraseReq.kind, KIND_NONE);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    tick(6);
    cmpVal(eraseFillData, ERASED_BYTE);
    cmpVal(eraseReq.kind, KIND_NONE);
    // block erase in both layouts, lowest and highest block, one trailing partial byte
    for (int i = 0; i < 6; i++) begin
      pg = 12'($random(seed));
      if (i == 2) pg[11:3] = 9'h000;
      if (i == 3) pg[11:3] = 9'h1FF;
      @(posedge clk) pageMode256 <= i[0];
      go({OP_BLOCK_ERASE, mkAddr(pg, i[0]), 16'h0}, (i == 4) ? 37 : 32, 1'b1);
      cmpVal(eraseReq.kind, KIND_BLOCK);
      cmpVal(eraseReq.block, pg[11:3]);
      cmpBit(status.eraseProgramErrorFlag, 1'b0);
      if (i == 1) inject();
      waitDone(BLK);
    end
    // sector erase: both small sectors, first and last large one, then random
    for (int i = 0; i < 10; i++) begin
      m = 1'($random(seed));
      pg = 12'($random(seed));
      if (i < 2) pg[11:8] = 4'h0;
      if (i < 2) pg[3] = i[0];
      if (i == 2) pg[11:8] = 4'h1;
      if (i == 3) pg[11:8] = 4'hF;
      @(posedge clk) pageMode256 <= m;
      go({OP_SECTOR_ERASE, mkAddr(pg, m), 16'h0}, 32, 1'b1);
      cmpVal(eraseReq.kind, KIND_SECTOR);
      cmpVal(eraseReq.sector, expSector(pg));
      if (i == 5) inject();
      waitDone(SEC);
    end
    // chip erase with trailing bytes, protect pin and an ignored frame mid-erase
    @(posedge clk) sectorProtect <= SECTOR_COUNT'($random(seed));
    go({CHIP_SEQ_0, CHIP_SEQ_1, CHIP_SEQ_2, CHIP_SEQ_3, 16'hA55A}, 48, 1'b1);
    cmpVal(eraseReq.kind, KIND_CHIP);
    cmpVal(eraseReq.sectorMask, {15'h0, ~sectorProtect});
    @(posedge clk) wpN <= 1'b0;
    n = starts;
    host.sendFrame({OP_BLOCK_ERASE, 24'h0, 16'h0}, 32);
    inject();
    waitDone(CHP);
    cmpVal(starts, n);
    cmpBit(wpSeen, 1'b0);
    tick(4);
    cmpBit(wpActive, 1'b1);
    @(posedge clk) wpN <= 1'b1;
    tick(4);
    cmpBit(wpActive, 1'b0);
    // refused frames: each chip byte spoiled, short frames, unknown opcode
    for (int j = 0; j < 7; j++) begin
      f = {CHIP_SEQ_0, CHIP_SEQ_1, CHIP_SEQ_2, CHIP_SEQ_3, 16'h0};
      if (j < 4) f[47 - 8 * j] = ~f[47 - 8 * j];
      if (j == 4) f[47:40] = OP_BLOCK_ERASE;
      if (j == 5) f[47:40] = OP_SECTOR_ERASE;
      if (j == 6) f[47:40] = 8'h51;
      go(f, (j == 4) ? 24 : (j == 5) ? 31 : 32, 1'b0);
    end
    give_verdict();
  end
endmodule

/* File: sfe_erase_seq.sv */
// block, sector and chip erase command sequencer behind the serial slave pins
// assumes link pins are asynchronous to clk and the array reports failed bytes on byteFailDet
`timescale 1ns/1ps
module sfe_erase_seq
  import sfe_pkg::*;
#(
  parameter int BLOCK_CYCLES = sfe_pkg::BLOCK_ERASE_CYCLES,
  parameter int SECTOR_CYCLES = sfe_pkg::SECTOR_ERASE_CYCLES,
  parameter int CHIP_CYCLES = sfe_pkg::CHIP_ERASE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic wpN,
  input wire logic pageMode256,
  input wire logic [sfe_pkg::SECTOR_COUNT-1:0] sectorProtect,
  input wire logic byteFailDet,
  output sfe_pkg::sfe_status_type status,
  output sfe_pkg::sfe_req_type eraseReq,
  output logic eraseStart,
  output logic wpActive,
  output logic [7:0] eraseFillData
);
  import sfe_pkg::*;

  typedef enum {ST_IDLE, ST_ERASE} sfe_state_type;

  sfe_state_type state;
  logic [2:0] sckSync, csSync, mosiSync, wpSync;
  logic sckRise, csRise, csFall;
  logic [7:0] shiftIn;
  logic [2:0] bitCnt, byteCnt;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic chipSeqOk;
  logic [7:0] nextByte;
  logic byteDone;
  logic launch;
  sfe_req_type next_req;
  logic [COUNT_BITS-1:0] loadCount;
  logic timerBusy, timerDone;
  logic busyFlag, errFlag;

  // ==========================================================
  // pin synchronisers; edges judged on stages two and three only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sckSync <= 3'h0;
      csSync <= 3'h7;
      mosiSync <= 3'h0;
      wpSync <= 3'h7;
    end else begin
      sckSync <= {sckSync[1:0], sck};
      csSync <= {csSync[1:0], csN};
      mosiSync <= {mosiSync[1:0], mosi};
      wpSync <= {wpSync[1:0], wpN};
    end
  end

  assign sckRise = sckSync[1] & ~sckSync[2] & ~csSync[2];
  assign csRise = csSync[1] & ~csSync[2];
  assign csFall = ~csSync[1] & csSync[2];
  assign nextByte = {shiftIn[6:0], mosiSync[1]};
  assign byteDone = sckRise && (bitCnt == BIT_CNT_LAST);

  // ==========================================================
  // byte assembly, mode 0: data sampled on the rising clock edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shiftIn <= 8'h00;
      bitCnt <= 3'h0;
      byteCnt <= 3'h0;
    end else if (csFall) begin
      bitCnt <= 3'h0;
      byteCnt <= 3'h0;
    end else if (sckRise) begin
      shiftIn <= nextByte;
      bitCnt <= bitCnt + 3'h1;
      if (byteDone && byteCnt != BYTE_CNT_MAX) begin
        byteCnt <= byteCnt + 3'h1; // saturates so trailing bytes are harmless
      end
    end
  end

  // ==========================================================
  // opcode, address and chip sequence capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opcode <= 8'h00;
      addr <= 24'h000000;
      chipSeqOk <= 1'b0;
    end else if (csFall) begin
      opcode <= 8'h00;
      chipSeqOk <= 1'b0;
    end else if (byteDone) begin
      unique case (byteCnt)
        3'h0: begin
          opcode <= nextByte;
          chipSeqOk <= (nextByte == CHIP_SEQ_0);
        end
        3'h1: begin
          addr[23:16] <= nextByte;
          chipSeqOk <= chipSeqOk && (nextByte == CHIP_SEQ_1);
        end
        3'h2: begin
          addr[15:8] <= nextByte;
          chipSeqOk <= chipSeqOk && (nextByte == CHIP_SEQ_2);
        end
        3'h3: begin
          addr[7:0] <= nextByte;
          chipSeqOk <= chipSeqOk && (nextByte == CHIP_SEQ_3);
        end
        default: begin
          chipSeqOk <= chipSeqOk;
        end
      endcase
    end
  end

  // ==========================================================
  // request decode at chip select release; short frames start nothing
  always_comb begin
    logic [PAGE_BITS-1:0] page;
    page = pageOf(addr, pageMode256);
    next_req = '0;
    next_req.block = page[BLOCK_LSB +: BLOCK_BITS];
    next_req.sector = sectorOf(page);
    loadCount = COUNT_BITS'(BLOCK_CYCLES);
    if (byteCnt >= BYTE_CNT_FULL && chipSeqOk) begin
      next_req.kind = KIND_CHIP;
      next_req.sectorMask = ~sectorProtect;
      loadCount = COUNT_BITS'(CHIP_CYCLES);
    end else if (byteCnt >= BYTE_CNT_FULL && opcode == OP_BLOCK_ERASE) begin
      next_req.kind = KIND_BLOCK;
      next_req.sectorMask = SECTOR_COUNT'(1) << next_req.sector;
    end else if (byteCnt >= BYTE_CNT_FULL && opcode == OP_SECTOR_ERASE) begin
      next_req.kind = KIND_SECTOR;
      next_req.sectorMask = SECTOR_COUNT'(1) << next_req.sector;
      loadCount = COUNT_BITS'(SECTOR_CYCLES);
    end
  end

  assign launch = csRise && state == ST_IDLE && next_req.kind != KIND_NONE;

  sfe_erase_timer #(
    .COUNT_BITS(COUNT_BITS)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(launch),
    .loadCount(loadCount),
    .busy(timerBusy),
    .done(timerDone)
  );

  // ==========================================================
  // sequencer state and outgoing request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      eraseReq <= '0;
      eraseStart <= 1'b0;
      busyFlag <= 1'b0;
    end else begin
      eraseStart <= launch;
      unique case (state)
        ST_IDLE: begin
          if (launch) begin
            state <= ST_ERASE;
            eraseReq <= next_req;
            busyFlag <= 1'b1;
          end
        end
        ST_ERASE: begin
          if (timerDone) begin
            state <= ST_IDLE;
            busyFlag <= 1'b0;
            eraseReq.kind <= KIND_NONE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // error flag: cleared by a new erase, set by any failing byte while busy
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      errFlag <= 1'b0;
    end else if (busyFlag && byteFailDet) begin
      errFlag <= 1'b1;
    end else if (launch) begin
      errFlag <= 1'b0;
    end
  end

  // status word gathers both flags; each flag keeps a single driving process
  assign status = '{busy: busyFlag, eraseProgramErrorFlag: errFlag};

  // ==========================================================
  // write protect is only picked up between erases so an erase in flight finishes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wpActive <= 1'b0;
      eraseFillData <= ERASED_BYTE;
    end else begin
      eraseFillData <= ERASED_BYTE;
      if (state == ST_IDLE && !launch) begin
        wpActive <= ~wpSync[2];
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence seqLaunch;
    csRise && state == ST_IDLE && next_req.kind != KIND_NONE;
  endsequence

  sequence seqBusyUp;
    status.busy && eraseStart;
  endsequence

  chk_start_busy: assert property (seqLaunch |=> seqBusyUp)
    else $error("busy did not rise after a valid erase request");
  chk_short_frame: assert property (csRise && byteCnt < BYTE_CNT_FULL |=> !eraseStart)
    else $error("erase started on a short frame");
  chk_block_index: assert property (launch && next_req.kind == KIND_BLOCK |=>
      eraseReq.block == $past(pageOf(addr, pageMode256)) >> BLOCK_LSB)
    else $error("block index mismatch");
  chk_chip_mask: assert property (launch && next_req.kind == KIND_CHIP |=>
      (eraseReq.sectorMask & $past(sectorProtect)) == '0)
    else $error("chip erase touches a protected sector");
  chk_chip_exact: assert property (launch && next_req.kind == KIND_CHIP |->
      opcode == CHIP_SEQ_0 && addr == {CHIP_SEQ_1, CHIP_SEQ_2, CHIP_SEQ_3})
    else $error("chip erase without the exact sequence");
  chk_busy_drop: assert property (timerDone |=> !status.busy && state == ST_IDLE)
    else $error("busy held after erase finished");
  chk_error_set: assert property (status.busy && byteFailDet |=> status.eraseProgramErrorFlag)
    else $error("failed byte did not set the error flag");
  chk_wp_hold: assert property (state == ST_ERASE ##1 state == ST_ERASE |-> $stable(wpActive))
    else $error("write protect changed during an erase");
  chk_one_sector: assert property (launch && next_req.kind == KIND_SECTOR |=>
      $onehot(eraseReq.sectorMask))
    else $error("sector erase mask not one sector");
  chk_fill_ones: assert property (eraseFillData == ERASED_BYTE)
    else $error("erased byte value not all ones");

endmodule

/* File: sfe_erase_timer.sv */
// self-timed erase countdown: loads a cycle count on start, pulses done at the end
// assumes start only arrives while not busy
`timescale 1ns/1ps
module sfe_erase_timer #(
  parameter int COUNT_BITS = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [COUNT_BITS-1:0] loadCount,
  output logic busy,
  output logic done
);

  logic [COUNT_BITS-1:0] remain;

  // ==========================================================
  // countdown; a zero load still takes one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      remain <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain <= (loadCount == '0) ? COUNT_BITS'(1) : loadCount;
        busy <= 1'b1;
      end else if (busy) begin
        if (remain == COUNT_BITS'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        remain <= remain - COUNT_BITS'(1);
      end
    end
  end

endmodule

/* File: sfe_host_model.sv */
// host serial master model that frames erase commands for the sequencer
// assumes clock mode 0, bits sent MSB first, a 125 ns link period
`timescale 1ns/1ps
module sfe_host_model (
  output logic sck,
  output logic csN,
  output logic mosi
);
  // ==========================================================
  // idle levels
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end

  // ==========================================================
  // frame driver
  // sck rests low outside frames; after release the data line flips so no stale bit is read
  task automatic sendFrame(input logic [47:0] data, input int nBits);
    csN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      mosi = data[47 - i];
      #62.5;
      sck = 1'b1;
      #62.5;
      sck = 1'b0;
    end
    #62.5;
    csN = 1'b1;
    mosi = ~mosi;
    #100;
  endtask
endmodule

/* File: sfe_pkg.sv */
// constants, types and address decode shared by the erase sequencer files
// assumes a 125 MHz system clock and a serial host link in clock mode 0
package sfe_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
  localparam logic [7:0] CHIP_SEQ_0 = 8'hC7;
  localparam logic [7:0] CHIP_SEQ_1 = 8'h94;
  localparam logic [7:0] CHIP_SEQ_2 = 8'h80;
  localparam logic [7:0] CHIP_SEQ_3 = 8'h9A;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ==========================================================
  // framing and address layout
  localparam logic [2:0] BYTE_CNT_OPCODE = 3'h1;
  localparam logic [2:0] BYTE_CNT_FULL = 3'h4;
  localparam logic [2:0] BYTE_CNT_MAX = 3'h5;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam int PAGE_BITS = 12;
  localparam int BLOCK_BITS = 9;
  localparam int SECTOR_ID_BITS = 5;
  localparam int SECTOR_COUNT = 17;
  localparam int PAGE264_LSB = 9;
  localparam int PAGE256_LSB = 8;
  localparam int BLOCK_LSB = 3;
  localparam int SECTOR_LSB = 8;
  localparam int SMALL_SEL_BIT = 3;
  localparam logic [SECTOR_ID_BITS-1:0] SECTOR_ID_0A = 5'h00;
  localparam logic [SECTOR_ID_BITS-1:0] SECTOR_ID_0B = 5'h01;

  // ==========================================================
  // timing; erase times are plain defaults, counts round down
  localparam int CLK_PERIOD_NS = 8;
  localparam int BLOCK_ERASE_TIME_US = 1000;
  localparam int SECTOR_ERASE_TIME_US = 4000;
  localparam int CHIP_ERASE_TIME_US = 16000;
  localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int COUNT_BITS = 32;

  typedef enum logic [1:0] {KIND_NONE, KIND_BLOCK, KIND_SECTOR, KIND_CHIP} sfe_kind_type;

  typedef struct packed {
    sfe_kind_type kind;
    logic [BLOCK_BITS-1:0] block;
    logic [SECTOR_ID_BITS-1:0] sector;
    logic [SECTOR_COUNT-1:0] sectorMask;
  } sfe_req_type;

  typedef struct packed {
    logic busy;
    logic eraseProgramErrorFlag;
  } sfe_status_type;

  // page number from the three address bytes in either page mode
  function automatic logic [PAGE_BITS-1:0] pageOf(input logic [23:0] addr, input logic mode256);
    pageOf = mode256 ? addr[PAGE256_LSB +: PAGE_BITS] : addr[PAGE264_LSB +: PAGE_BITS];
  endfunction

  // small sectors 0a/0b get ids 0/1, sector n gets n+1
  function automatic logic [SECTOR_ID_BITS-1:0] sectorOf(input logic [PAGE_BITS-1:0] page);
    logic [3:0] upper;
    upper = page[SECTOR_LSB +: 4];
    if (upper == 4'h0) begin
      sectorOf = page[SMALL_SEL_BIT] ? SECTOR_ID_0B : SECTOR_ID_0A;
    end else begin
      sectorOf = {1'b0, upper} + SECTOR_ID_0B;
    end
  endfunction

endpackage
